// *** bench/partner_neg_model.sv ***
// Link partner model: drives negotiated abilities and status events.
// Assumes the bench calls its tasks and core_clk runs all the time.
`timescale 1ns/1ps
module partner_neg_model (
  // Clock
  input  wire logic core_clk,
  // Abilities and events toward the bank
  output logic       partner_ten_full_duplex,
  output logic       partner_ten_half_duplex,
  output logic [4:0] partner_selector,
  output logic       partner_update,
  output logic       partner_next_page_able,
  output logic       partner_autoneg_able,
  output logic       parallel_detect_fault,
  output logic       page_received
);
  // Idle levels at time zero
  initial begin
    {partner_ten_full_duplex, partner_ten_half_duplex, partner_update} = 3'h0;
    {partner_next_page_able, partner_autoneg_able} = 2'h0;
    {parallel_detect_fault, page_received} = 2'h0;
    partner_selector = 5'h00;
  end
  // One base page, then the duplex and selector lines go stale (inverted) after the load; next page and autoneg hold
  task automatic advertise(input logic fd, input logic hd, input logic [4:0] sel,
                           input logic np, input logic an);
    @(posedge core_clk);
    partner_ten_full_duplex <= fd;
    partner_ten_half_duplex <= hd;
    partner_selector        <= sel;
    partner_next_page_able  <= np;
    partner_autoneg_able    <= an;
    partner_update          <= 1'b1;
    @(posedge core_clk);
    partner_update          <= 1'b0;
    partner_ten_full_duplex <= ~fd;
    partner_ten_half_duplex <= ~hd;
    partner_selector        <= ~sel;
  endtask : advertise
  // One-cycle page and fault events
  task automatic pulse(input logic pg, input logic flt);
    @(posedge core_clk);
    page_received         <= pg;
    parallel_detect_fault <= flt;
    @(posedge core_clk);
    page_received         <= 1'b0;
    parallel_detect_fault <= 1'b0;
  endtask : pulse
endmodule : partner_neg_model

// *** bench/tb_phy_autoneg_status_vendor_config.sv ***
// Bench for the PHY auto-negotiation status and vendor config bank.
// Assumes the design package is compiled first and the partner model beside it.
`timescale 1ns/1ps
module tb_phy_autoneg_status_vendor_config;
  logic        core_clk;
  logic        rst_n;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  wire         fd, hd, upd, np, an, flt, pg, smr;
  wire  [4:0]  sel;
  wire  [15:0] outs;
  int          fails;
  int          checks;
  int          n;

  // Design and link partner
  phy_autoneg_status_vendor_config dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .partner_ten_full_duplex(fd), .partner_ten_half_duplex(hd),
    .partner_selector(sel), .partner_update(upd), .partner_next_page_able(np),
    .partner_autoneg_able(an), .parallel_detect_fault(flt), .page_received(pg),
    .bypass_block_coder(outs[15]), .bypass_scrambler(outs[14]),
    .bypass_symbol_alignment(outs[13]), .force_signal_detect(outs[12]),
    .copper_fiber_select(outs[10]), .force_link_100(outs[7]),
    .auto_reduced_power_enable(outs[4]), .state_machine_reset(smr),
    .mgmt_preamble_suppress(outs[2]), .sleep_power_down(outs[1]), .remote_loopout(outs[0]));
  partner_neg_model lp (.core_clk(core_clk), .partner_ten_full_duplex(fd),
    .partner_ten_half_duplex(hd), .partner_selector(sel), .partner_update(upd),
    .partner_next_page_able(np), .partner_autoneg_able(an), .parallel_detect_fault(flt),
    .page_received(pg));
  // Output vector bits with no control behind them
  assign {outs[11], outs[9], outs[8], outs[6], outs[5], outs[3]} = 6'h00;

  // Verdict and end of run
  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // One-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Cycles with the state machine reset high
  task automatic count_smr;
    n = 0;
    repeat (12) begin
      @(posedge core_clk);
      #1 if (smr === 1'b1) n++;
    end
  endtask : count_smr

  // Reset values of all three registers and the outputs
  task automatic t_reset;
    rd(5'h05, 16'h0000);
    rd(5'h06, 16'h0000);
    rd(5'h10, 16'h0414);
    chk(outs & 16'hF497, 16'h0414);
  endtask : t_reset
  // Partner page capture, read-only registers, unmapped read
  task automatic t_partner;
    lp.advertise(1'b1, 1'b0, 5'h01, 1'b1, 1'b1);
    rd(5'h05, 16'h0041);
    lp.advertise(1'b0, 1'b1, 5'h1E, 1'b1, 1'b1);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h003E);
    wr(5'h06, 16'hFFFF);
    rd(5'h06, 16'h0009);
    rd(5'h1F, 16'h0000);
  endtask : t_partner
  // Latched fault stays, page flag clears on read
  task automatic t_events;
    lp.pulse(1'b1, 1'b1);
    rd(5'h06, 16'h001B);
    rd(5'h06, 16'h0019);
  endtask : t_events
  // Every control bit except 16.3 out, all but 16.1 back, reserved read-only bit ignored
  task automatic t_config;
    wr(5'h10, 16'hF695);
    rd(5'h10, 16'hF495);
    chk(outs & 16'hF497, 16'hF495);
    wr(5'h10, 16'h0002);
    #1 chk(outs & 16'hF497, 16'h0002);
  endtask : t_config
  // Self-clearing state machine reset, and wake from sleep
  task automatic t_sm_reset;
    wr(5'h10, 16'h0400);
    count_smr();
    chk(16'(n), 16'h0004);
    wr(5'h10, 16'h0408);
    count_smr();
    chk(16'(n), 16'h0004);
    rd(5'h10, 16'h0400);
  endtask : t_sm_reset

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Main sequence
  initial begin
    {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_partner();
    t_events();
    t_config();
    t_sm_reset();
    end_sim();
  end
  // Watchdog
  initial begin
    #50000;
    fails++;
    end_sim();
  end
endmodule : tb_phy_autoneg_status_vendor_config

// *** src/phy_autoneg_status_vendor_config.sv ***
// PHY management register bank: partner ability, expansion, vendor config.
// Assumes partner inputs come from auto-negotiation logic on core_clk.
//
// What this block does
// - Partner ability register filled by negotiation, read-only
// - Bit 5.6 shows partner ten full duplex
// - Bit 5.5 shows partner ten half duplex
// - Bits 4..0 hold partner selector code
// - Expansion bits 15..5 read zero always
// - Parallel detect fault latched high
// - Bit 6.3 shows partner next page able
// - Local next page able reads zero
// - Page received latched, cleared by expansion read
// - Bit 6.0 shows partner autoneg able
// - Bit 16.15 bypasses block coder
// - Bit 16.14 bypasses scrambler and descrambler
// - Bit 16.13 bypasses alignment and coding path
// - Bit 16.12 forces signal detect active
// - Bit 16.10 selects copper or fiber
// - Bit 16.7 forces good link at 100
// - Bit 16.4 enables auto reduced power
// - Bit 16.3 resets state machines, self-clears
// - Bit 16.2 enables preamble suppression
// - Sleep powers down; wake resets state machines
// - Bit 16.0 loops receive data out
`timescale 1ns/1ps

module phy_autoneg_status_vendor_config (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Partner abilities from negotiation
  input  wire logic        partner_ten_full_duplex,
  input  wire logic        partner_ten_half_duplex,
  input  wire logic [4:0]  partner_selector,
  input  wire logic        partner_update,
  input  wire logic        partner_next_page_able,
  input  wire logic        partner_autoneg_able,
  input  wire logic        parallel_detect_fault,
  input  wire logic        page_received,
  // Controls to the transceiver
  output logic             bypass_block_coder,
  output logic             bypass_scrambler,
  output logic             bypass_symbol_alignment,
  output logic             force_signal_detect,
  output logic             copper_fiber_select,
  output logic             force_link_100,
  output logic             auto_reduced_power_enable,
  output logic             state_machine_reset,
  output logic             mgmt_preamble_suppress,
  output logic             sleep_power_down,
  output logic             remote_loopout
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] partner;
    logic        fault;
    logic        lp_np;
    logic        page_rx;
    logic        lp_an;
    logic [15:0] cfg;
    logic [3:0]  rst_cnt;
    logic        sleep_prev;
    logic [15:0] rdata;
  } state_s;

  state_s st;
  state_s next_st;

  logic rd_exp;
  logic wr_cfg;
  logic wake;

  assign rd_exp = reg_rd && (reg_addr == phy_regs_pkg::autoneg_expansion_addr);
  assign wr_cfg = reg_wr && (reg_addr == phy_regs_pkg::vendor_config_addr);
  assign wake   = st.sleep_prev && !st.cfg[phy_regs_pkg::vc_sleep_bit];

  // Next-state logic for all registers
  always_comb begin
    next_st = st;
    // Partner ability captured on each negotiation update
    if (partner_update) begin
      next_st.partner = 16'h0000;
      next_st.partner[phy_regs_pkg::pa_ten_full_bit] = partner_ten_full_duplex;
      next_st.partner[phy_regs_pkg::pa_ten_half_bit] = partner_ten_half_duplex;
      next_st.partner[phy_regs_pkg::pa_sel_lsb +: 5] = partner_selector;
    end
    next_st.lp_np = partner_next_page_able;
    next_st.lp_an = partner_autoneg_able;
    // Latched-high status; a new event beats the read clear
    next_st.fault = st.fault || parallel_detect_fault;
    if (rd_exp) begin
      next_st.page_rx = 1'b0;
    end
    if (page_received) begin
      next_st.page_rx = 1'b1;
    end
    // Configuration write; reserved read-only bit masked
    if (wr_cfg) begin
      next_st.cfg = reg_wdata & phy_regs_pkg::vc_write_mask;
    end
    // Self-clearing state machine reset, also started on wake
    next_st.sleep_prev = st.cfg[phy_regs_pkg::vc_sleep_bit]; // One cycle behind, so wake can see 1->0
    if (st.rst_cnt != 4'h0) begin
      next_st.rst_cnt = st.rst_cnt - 4'h1;
      if (st.rst_cnt == 4'h1) begin
        next_st.cfg[phy_regs_pkg::vc_sm_reset_bit] = 1'b0;
      end
    end else if (st.cfg[phy_regs_pkg::vc_sm_reset_bit] || wake) begin
      next_st.rst_cnt = phy_regs_pkg::sm_reset_cycles;
    end
    // Read data, valid the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        phy_regs_pkg::partner_ability_addr: next_st.rdata = st.partner;
        phy_regs_pkg::autoneg_expansion_addr: begin
          next_st.rdata[phy_regs_pkg::ex_fault_bit]   = st.fault;
          next_st.rdata[phy_regs_pkg::ex_lp_np_bit]   = st.lp_np;
          next_st.rdata[phy_regs_pkg::ex_np_bit]      = 1'b0;
          next_st.rdata[phy_regs_pkg::ex_page_rx_bit] = st.page_rx;
          next_st.rdata[phy_regs_pkg::ex_lp_an_bit]   = st.lp_an;
        end
        phy_regs_pkg::vendor_config_addr: next_st.rdata = st.cfg;
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  // State register with clock enable and synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st.partner    <= {11'h000, phy_regs_pkg::pa_sel_reset};
      st.fault      <= 1'b0;
      st.lp_np      <= 1'b0;
      st.page_rx    <= 1'b0;
      st.lp_an      <= 1'b0;
      st.cfg        <= phy_regs_pkg::vc_reset;
      st.rst_cnt    <= 4'h0;
      st.sleep_prev <= 1'b0;
      st.rdata      <= 16'h0000;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata                 = st.rdata;
  assign bypass_block_coder        = st.cfg[phy_regs_pkg::vc_block_coder_bit];
  assign bypass_scrambler          = st.cfg[phy_regs_pkg::vc_scrambler_bit];
  assign bypass_symbol_alignment   = st.cfg[phy_regs_pkg::vc_align_bit];
  assign force_signal_detect       = st.cfg[phy_regs_pkg::vc_force_detect_bit];
  assign copper_fiber_select       = st.cfg[phy_regs_pkg::vc_copper_fiber_bit];
  assign force_link_100            = st.cfg[phy_regs_pkg::vc_force_link_bit];
  assign auto_reduced_power_enable = st.cfg[phy_regs_pkg::vc_reduced_pwr_bit];
  assign state_machine_reset       = (st.rst_cnt != 4'h0);
  assign mgmt_preamble_suppress    = st.cfg[phy_regs_pkg::vc_preamble_bit];
  assign sleep_power_down          = st.cfg[phy_regs_pkg::vc_sleep_bit];
  assign remote_loopout            = st.cfg[phy_regs_pkg::vc_loopout_bit];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  exp_upper_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_exp |=> reg_rdata[15:5] == 11'h000)
    else $error("expansion upper bits not zero");

  local_next_page_able_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_exp |=> !reg_rdata[2])
    else $error("local next page able set");

  page_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_exp && !page_received |=> !st.page_rx)
    else $error("page received not cleared");

  page_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && page_received |=> st.page_rx)
    else $error("page received lost");

  fault_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && parallel_detect_fault |=> st.fault)
    else $error("fault not latched");

  ro_bit_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.cfg[phy_regs_pkg::vc_reserved_ro_bit])
    else $error("reserved config bit set");

  cfg_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=> copper_fiber_select == $past(reg_wdata[10]))
    else $error("copper fiber select not written");

  smr_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && $rose(st.cfg[phy_regs_pkg::vc_sm_reset_bit]) && st.rst_cnt == 4'h0
      |=> state_machine_reset)
    else $error("state machine reset not started");

  partner_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && partner_update |=> st.partner[6] == $past(partner_ten_full_duplex))
    else $error("partner full duplex not captured");

  // ----------------------------------------------------------------
  // Partner ability checks
  // ----------------------------------------------------------------

  partner_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !partner_update |=> $stable(st.partner))
    else $error("partner ability changed without update");

  partner_upper_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.partner[15:7] == 9'h000)
    else $error("partner ability upper bits set");

  partner_wr_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == phy_regs_pkg::partner_ability_addr && !partner_update
      |=> $stable(st.partner))
    else $error("partner ability written by management");

  partner_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == phy_regs_pkg::partner_ability_addr
      |=> reg_rdata == $past(st.partner))
    else $error("partner ability read wrong");

  partner_half_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && partner_update |=> st.partner[5] == $past(partner_ten_half_duplex))
    else $error("partner half duplex not captured");

  partner_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && partner_update |=> st.partner[4:0] == $past(partner_selector))
    else $error("partner selector not captured");

  // ----------------------------------------------------------------
  // Expansion checks
  // ----------------------------------------------------------------

  lp_np_track_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> st.lp_np == $past(partner_next_page_able))
    else $error("partner next page flag not tracked");

  exp_np_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_exp |=> reg_rdata[3] == $past(st.lp_np))
    else $error("partner next page read wrong");

  lp_an_track_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> st.lp_an == $past(partner_autoneg_able))
    else $error("partner autoneg flag not tracked");

  exp_an_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_exp |=> reg_rdata[0] == $past(st.lp_an))
    else $error("partner autoneg read wrong");

  fault_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st.fault |=> st.fault)
    else $error("fault flag dropped");

  exp_fault_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_exp |=> reg_rdata[4] == $past(st.fault))
    else $error("fault flag read wrong");

  page_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_exp |=> reg_rdata[1] == $past(st.page_rx))
    else $error("page flag read wrong");

  page_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !rd_exp && !page_received |=> st.page_rx == $past(st.page_rx))
    else $error("page flag changed without cause");

  exp_wr_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == phy_regs_pkg::autoneg_expansion_addr
      && !page_received && !parallel_detect_fault
      |=> st.page_rx == $past(st.page_rx) && st.fault == $past(st.fault))
    else $error("expansion flags written by management");

  // ----------------------------------------------------------------
  // Configuration and read data checks
  // ----------------------------------------------------------------

  bypass_coder_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      bypass_block_coder == $past(reg_wdata[phy_regs_pkg::vc_block_coder_bit]))
    else $error("block coder bypass not written");

  bypass_scr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      bypass_scrambler == $past(reg_wdata[phy_regs_pkg::vc_scrambler_bit]))
    else $error("scrambler bypass not written");

  bypass_align_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      bypass_symbol_alignment == $past(reg_wdata[phy_regs_pkg::vc_align_bit]))
    else $error("alignment bypass not written");

  force_detect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      force_signal_detect == $past(reg_wdata[phy_regs_pkg::vc_force_detect_bit]))
    else $error("forced signal detect not written");

  force_link_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      force_link_100 == $past(reg_wdata[phy_regs_pkg::vc_force_link_bit]))
    else $error("forced link not written");

  reduced_pwr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      auto_reduced_power_enable == $past(reg_wdata[phy_regs_pkg::vc_reduced_pwr_bit]))
    else $error("reduced power enable not written");

  preamble_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      mgmt_preamble_suppress == $past(reg_wdata[phy_regs_pkg::vc_preamble_bit]))
    else $error("preamble suppression not written");

  sleep_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      sleep_power_down == $past(reg_wdata[phy_regs_pkg::vc_sleep_bit]))
    else $error("sleep not written");

  loopout_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=>
      remote_loopout == $past(reg_wdata[phy_regs_pkg::vc_loopout_bit]))
    else $error("remote loopout not written");

  cfg_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !wr_cfg |=>
      st.cfg[15:4] == $past(st.cfg[15:4]) && st.cfg[2:0] == $past(st.cfg[2:0]))
    else $error("configuration changed without write");

  ro_write_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_cfg |=> !st.cfg[phy_regs_pkg::vc_reserved_ro_bit])
    else $error("reserved config bit took a write");

  cfg_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == phy_regs_pkg::vendor_config_addr
      |=> reg_rdata == $past(st.cfg))
    else $error("configuration read wrong");

  ro_read_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == phy_regs_pkg::vendor_config_addr
      |=> !reg_rdata[phy_regs_pkg::vc_reserved_ro_bit])
    else $error("reserved config bit read as one");

  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero without read");

  unmapped_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr != phy_regs_pkg::partner_ability_addr
      && reg_addr != phy_regs_pkg::autoneg_expansion_addr
      && reg_addr != phy_regs_pkg::vendor_config_addr |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // State machine reset checks
  // ----------------------------------------------------------------

  wake_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wake && st.rst_cnt == 4'h0 |=> state_machine_reset)
    else $error("wake did not reset state machines");

  sleep_track_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> st.sleep_prev == $past(st.cfg[phy_regs_pkg::vc_sleep_bit]))
    else $error("sleep history not tracked");

  smr_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st.rst_cnt != 4'h0 |=> st.rst_cnt == $past(st.rst_cnt) - 4'h1)
    else $error("reset counter not counting down");

  smr_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st.rst_cnt == 4'h1 |=> !st.cfg[phy_regs_pkg::vc_sm_reset_bit])
    else $error("reset bit not self-cleared");

  smr_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st.rst_cnt == 4'h0 && !st.cfg[phy_regs_pkg::vc_sm_reset_bit] && !wake
      |=> !state_machine_reset)
    else $error("state machine reset without cause");

endmodule : phy_autoneg_status_vendor_config

// *** src/phy_regs_pkg.sv ***
// Package for the PHY auto-negotiation status and vendor configuration bank.
// Assumes a 16-bit management register space addressed by register number.
package phy_regs_pkg;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] partner_ability_addr   = 5'h05;
  localparam logic [4:0] autoneg_expansion_addr = 5'h06;
  localparam logic [4:0] vendor_config_addr     = 5'h10;

  // ----------------------------------------------------------------
  // Partner ability fields
  // ----------------------------------------------------------------
  localparam int          pa_ten_full_bit = 6;
  localparam int          pa_ten_half_bit = 5;
  localparam int          pa_sel_lsb      = 0;
  localparam logic [4:0]  pa_sel_reset    = 5'h00;

  // ----------------------------------------------------------------
  // Expansion fields
  // ----------------------------------------------------------------
  localparam int ex_fault_bit   = 4;
  localparam int ex_lp_np_bit   = 3;
  localparam int ex_np_bit      = 2;
  localparam int ex_page_rx_bit = 1;
  localparam int ex_lp_an_bit   = 0;

  // ----------------------------------------------------------------
  // Vendor configuration fields
  // ----------------------------------------------------------------
  localparam int vc_block_coder_bit  = 15;
  localparam int vc_scrambler_bit    = 14;
  localparam int vc_align_bit        = 13;
  localparam int vc_force_detect_bit = 12;
  localparam int vc_copper_fiber_bit = 10;
  localparam int vc_reserved_ro_bit  = 9;
  localparam int vc_force_link_bit   = 7;
  localparam int vc_reduced_pwr_bit  = 4;
  localparam int vc_sm_reset_bit     = 3;
  localparam int vc_preamble_bit     = 2;
  localparam int vc_sleep_bit        = 1;
  localparam int vc_loopout_bit      = 0;

  // Writable bits (16.9 excluded) and reset value
  localparam logic [15:0] vc_write_mask = 16'hFDFF;
  localparam logic [15:0] vc_reset      = 16'h0414;

  // Cycles the state machine reset pulse is held
  localparam logic [3:0]  sm_reset_cycles = 4'h4;

endpackage : phy_regs_pkg
